// File: common/gxp_pkg.sv
// constants of the sixteen-pin gpio expander port
`default_nettype none
// Behaviour
// - direction bit 0 makes the pin an output, 1 makes it an input.
// - after reset every pin is an input.
// - pin state read of an input returns its present level after inversion.
// - invert bit 1 reports the inverted level, 0 the true level.
// - pin state read of an output returns the output level register bit.
// - writes to the pin state registers are ignored.
// - output pins whose tristate bit is 0 are driven to their output level register bit.
// - output level register reads back the value last written.
// - pull-up bit 1 enables the pull-up on an input pin, 0 disables it; all off after reset.
// - interrupt enable bit 1 lets the input raise interrupts; all clear after reset.
// - an output pin never raises an interrupt.
// - an input with interrupt enable 0 never raises an interrupt.
// - no edge bits: any edge raises; cleared by read or return to read level.
// - filter on: new level must persist over 1075 ns; off: edge counts at once.
// - rising bit only: rising edge raises, only a pin state read clears.
// - falling bit only: falling edge raises, only a pin state read clears.
// - both edge bits: either edge raises, only a pin state read clears.
// - reading a bank's pin state clears that bank's pending interrupts.
// - low bank bits 7..0 are pins 7..0, high bank bits 7..0 are pins 15..8.
// - interrupt status registers show which inputs raised an interrupt.
// - filter enables reset to all ones.
package gxp_pkg;
  localparam int GXP_PINS = 16;
  localparam logic [7:0] GXP_STATE_LO = 8'h00;
  localparam logic [7:0] GXP_STATE_HI = 8'h01;
  localparam logic [7:0] GXP_OUT_LVL = 8'h02;
  localparam logic [7:0] GXP_INVERT = 8'h04;
  localparam logic [7:0] GXP_DIR = 8'h06;
  localparam logic [7:0] GXP_PULLUP = 8'h08;
  localparam logic [7:0] GXP_IRQ_EN = 8'h0a;
  localparam logic [7:0] GXP_TRISTATE = 8'h0c;
  localparam logic [7:0] GXP_IRQ_STAT = 8'h0e;
  localparam logic [7:0] GXP_RISE_SEL = 8'h10;
  localparam logic [7:0] GXP_FALL_SEL = 8'h12;
  localparam logic [7:0] GXP_FILT_EN = 8'h14;
  localparam logic [15:0] GXP_RST_OUT_LVL = 16'hffff;
  localparam logic [15:0] GXP_RST_INVERT = 16'h0000;
  localparam logic [15:0] GXP_RST_DIR = 16'hffff;
  localparam logic [15:0] GXP_RST_PULLUP = 16'h0000;
  localparam logic [15:0] GXP_RST_IRQ_EN = 16'h0000;
  localparam logic [15:0] GXP_RST_TRISTATE = 16'h0000;
  localparam logic [15:0] GXP_RST_EDGE_SEL = 16'h0000;
  localparam logic [15:0] GXP_RST_FILT_EN = 16'hffff;
  localparam int GXP_CLK_NS = 25;
  localparam int GXP_FILT_NS = 1075;
  localparam logic [5:0] GXP_FILT_CYC = 6'((GXP_FILT_NS + GXP_CLK_NS - 1) / GXP_CLK_NS);
endpackage
`default_nettype wire

// File: rtl/gxp_port.sv
// sixteen-pin gpio port with edge interrupts and glitch filter
`timescale 1ns/10ps
`default_nettype none
module gxp_port (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [gxp_pkg::GXP_PINS-1:0] gpio_in_i,
  output logic [gxp_pkg::GXP_PINS-1:0] gpio_out_o,
  output logic [gxp_pkg::GXP_PINS-1:0] gpio_oe_o,
  output logic [gxp_pkg::GXP_PINS-1:0] pullup_en_o,
  output logic irq_n_out_o,
  output logic irq_n_oe_o
);
  import gxp_pkg::*;

  logic [15:0] output_level;
  logic [15:0] input_invert;
  logic [15:0] direction;
  logic [15:0] pullup_enable;
  logic [15:0] irq_enable;
  logic [15:0] tristate;
  logic [15:0] rising_edge_select;
  logic [15:0] falling_edge_select;
  logic [15:0] glitch_filter_enable;
  logic [15:0] irq_status;
  logic [15:0] snap;
  logic [15:0] flt;
  logic [15:0] sync1;
  logic [15:0] pin_s;
  logic [5:0] cnt [16];

  // one command byte offset per bank register pair
  function automatic logic [15:0] wr_pair(input logic [15:0] cur, input logic [7:0] base);
    logic [15:0] v;
    v = cur;
    if (reg_wr_i && reg_addr_i == base) begin
      v[7:0] = reg_wdata_i;
    end
    if (reg_wr_i && reg_addr_i == 8'(base + 8'h01)) begin
      v[15:8] = reg_wdata_i;
    end
    return v;
  endfunction

  function automatic logic [7:0] bank(input logic [15:0] v, input logic hi);
    return hi ? v[15:8] : v[7:0];
  endfunction

  wire [15:0] state_view = (direction & (pin_s ^ input_invert)) | (~direction & output_level);
  wire rd_lo = reg_rd_i && reg_addr_i == GXP_STATE_LO;
  wire rd_hi = reg_rd_i && reg_addr_i == GXP_STATE_HI;
  wire [15:0] rd_mask = {{8{rd_hi}}, {8{rd_lo}}};
  wire [6:0] pair = reg_addr_i[7:1];
  wire hi_sel = reg_addr_i[0];

  // writes to offsets 0x00/0x01 match no pair below, so they are dropped
  wire [15:0] next_output_level = wr_pair(output_level, GXP_OUT_LVL);
  wire [15:0] next_input_invert = wr_pair(input_invert, GXP_INVERT);
  wire [15:0] next_direction = wr_pair(direction, GXP_DIR);
  wire [15:0] next_pullup_enable = wr_pair(pullup_enable, GXP_PULLUP);
  wire [15:0] next_irq_enable = wr_pair(irq_enable, GXP_IRQ_EN);
  wire [15:0] next_tristate = wr_pair(tristate, GXP_TRISTATE);
  wire [15:0] next_rising = wr_pair(rising_edge_select, GXP_RISE_SEL);
  wire [15:0] next_falling = wr_pair(falling_edge_select, GXP_FALL_SEL);
  wire [15:0] next_filter = wr_pair(glitch_filter_enable, GXP_FILT_EN);

  // edge detection and interrupt status, vectorised over all pins
  wire [15:0] upd;
  wire [15:0] next_flt = (flt & ~upd) | (pin_s & upd);
  wire [15:0] rise = upd & pin_s;
  wire [15:0] fall = upd & ~pin_s;
  wire [15:0] no_sel = ~rising_edge_select & ~falling_edge_select;
  wire [15:0] armed = irq_enable & direction;
  wire [15:0] next_snap = (rd_mask & flt) | (~rd_mask & snap);
  wire [15:0] moved = next_flt ^ next_snap;
  wire [15:0] edge_hit = (rising_edge_select & rise) | (falling_edge_select & fall);
  wire [15:0] irq_set = armed & ((~no_sel & edge_hit) | (no_sel & upd & moved));
  wire [15:0] irq_clr = rd_mask | (no_sel & ~moved);
  // a new event wins over a clear in the same cycle
  wire [15:0] next_irq_status = irq_set | (irq_status & ~irq_clr);

  logic [7:0] rd_word;
  always_comb begin
    case (pair)
      GXP_STATE_LO[7:1]: rd_word = bank(state_view, hi_sel);
      GXP_OUT_LVL[7:1]: rd_word = bank(output_level, hi_sel);
      GXP_INVERT[7:1]: rd_word = bank(input_invert, hi_sel);
      GXP_DIR[7:1]: rd_word = bank(direction, hi_sel);
      GXP_PULLUP[7:1]: rd_word = bank(pullup_enable, hi_sel);
      GXP_IRQ_EN[7:1]: rd_word = bank(irq_enable, hi_sel);
      GXP_TRISTATE[7:1]: rd_word = bank(tristate, hi_sel);
      GXP_IRQ_STAT[7:1]: rd_word = bank(irq_status, hi_sel);
      GXP_RISE_SEL[7:1]: rd_word = bank(rising_edge_select, hi_sel);
      GXP_FALL_SEL[7:1]: rd_word = bank(falling_edge_select, hi_sel);
      GXP_FILT_EN[7:1]: rd_word = bank(glitch_filter_enable, hi_sel);
      default: rd_word = 8'h00;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    sync1 <= gpio_in_i;
    pin_s <= sync1;
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      output_level <= GXP_RST_OUT_LVL;
      input_invert <= GXP_RST_INVERT;
      direction <= GXP_RST_DIR;
      pullup_enable <= GXP_RST_PULLUP;
      irq_enable <= GXP_RST_IRQ_EN;
      tristate <= GXP_RST_TRISTATE;
      rising_edge_select <= GXP_RST_EDGE_SEL;
      falling_edge_select <= GXP_RST_EDGE_SEL;
      glitch_filter_enable <= GXP_RST_FILT_EN;
      irq_status <= 16'h0000;
      snap <= 16'h0000;
      // start from the pin level so no false edge follows reset
      flt <= pin_s;
      reg_rdata_o <= 8'h00;
    end else begin
      output_level <= next_output_level;
      input_invert <= next_input_invert;
      direction <= next_direction;
      pullup_enable <= next_pullup_enable;
      irq_enable <= next_irq_enable;
      tristate <= next_tristate;
      rising_edge_select <= next_rising;
      falling_edge_select <= next_falling;
      glitch_filter_enable <= next_filter;
      irq_status <= next_irq_status;
      snap <= next_snap;
      flt <= next_flt;
      reg_rdata_o <= reg_rd_i ? rd_word : reg_rdata_o;
    end
  end

  // per-pin stability counter; level is taken once it has held FILT_CYC cycles
  genvar gi;
  for (gi = 0; gi < GXP_PINS; gi++) begin : g_filt
    assign upd[gi] = (pin_s[gi] != flt[gi]) &&
                     (!glitch_filter_enable[gi] || cnt[gi] == GXP_FILT_CYC);
    always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
        cnt[gi] <= 6'h00;
      end else if (pin_s[gi] == flt[gi] || upd[gi]) begin
        cnt[gi] <= 6'h00;
      end else begin
        cnt[gi] <= cnt[gi] + 6'h01;
      end
    end
  end

  assign gpio_out_o = output_level;
  assign gpio_oe_o = ~direction & ~tristate;
  assign pullup_en_o = pullup_enable & direction;
  assign irq_n_out_o = 1'b0;
  assign irq_n_oe_o = |irq_status;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  a_reset_all_inputs: assert property (!$past(resetn_i) |->
    gpio_oe_o == 16'h0000 && pullup_en_o == 16'h0000 && irq_n_oe_o == 1'b0)
    else $error("pins not inputs after reset");
  a_state_write_ignored: assert property (reg_wr_i && reg_addr_i[7:1] == 7'h00 |=>
    $stable(output_level) && $stable(direction) && $stable(input_invert))
    else $error("pin state write changed state");
  a_state_read_view: assert property (rd_lo |=> reg_rdata_o ==
    (($past(direction[7:0]) & ($past(pin_s[7:0]) ^ $past(input_invert[7:0]))) |
     (~$past(direction[7:0]) & $past(output_level[7:0]))))
    else $error("pin state read wrong");
  a_out_level_back: assert property (reg_wr_i && reg_addr_i == GXP_OUT_LVL ##2
    reg_rd_i && reg_addr_i == GXP_OUT_LVL |=> reg_rdata_o == $past(reg_wdata_i, 3))
    else $error("output level readback wrong");
  a_dir_write_lo: assert property (reg_wr_i && reg_addr_i == GXP_DIR |=>
    direction[7:0] == $past(reg_wdata_i))
    else $error("direction low write lost");
  a_dir_write_hi: assert property (reg_wr_i && reg_addr_i == 8'(GXP_DIR + 8'h01) |=>
    direction[15:8] == $past(reg_wdata_i))
    else $error("direction high write lost");
  a_rise_only_pin: assert property (!irq_status[0] && !rd_lo && armed[0] &&
    rising_edge_select[0] && !falling_edge_select[0] && fall[0] |=> !irq_status[0])
    else $error("falling edge raised rise-only interrupt");
  a_fall_only_pin: assert property (!irq_status[0] && !rd_lo && armed[0] &&
    !rising_edge_select[0] && falling_edge_select[0] && rise[0] |=> !irq_status[0])
    else $error("rising edge raised fall-only interrupt");
  a_filtered_set: assert property ($rose(irq_status[0]) && $past(glitch_filter_enable[0]) |->
    $past(cnt[0]) == GXP_FILT_CYC)
    else $error("filtered interrupt raised early");
  a_unmapped_zero: assert property (reg_rd_i && reg_addr_i > GXP_FILT_EN + 8'h01 |=>
    reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_holds: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data changed without read");
  a_no_out_irq: assert property ((|(irq_status & ~$past(irq_status) & ~$past(direction))) == 1'b0)
    else $error("output pin raised interrupt");
  a_no_dis_irq: assert property ((|(irq_status & ~$past(irq_status) & ~$past(irq_enable))) == 1'b0)
    else $error("disabled pin raised interrupt");
  a_filter_hold: assert property ($past(resetn_i) && $changed(flt[0]) &&
    $past(glitch_filter_enable[0]) |->
    $past(cnt[0]) == GXP_FILT_CYC)
    else $error("filtered level changed early");
  a_read_clears: assert property (rd_lo && (irq_set[7:0] == 8'h00) |=> irq_status[7:0] == 8'h00)
    else $error("pin state read did not clear");
  a_edge_sticky: assert property (irq_status[0] && !no_sel[0] && !rd_lo |=> irq_status[0])
    else $error("edge interrupt lost without read");
  a_irq_pin: assert property (irq_n_oe_o == (|irq_status) && irq_n_out_o == 1'b0)
    else $error("interrupt pin not asserted");
endmodule // gxp_port
`default_nettype wire

// File: testbench/gxp_master.sv
// register bus master model driving the gpio port
`timescale 1ns/10ps
`default_nettype none
module gxp_master (
  input wire logic mclk_i,
  output logic [7:0] reg_addr_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [7:0] reg_wdata_o
);
  initial begin
    reg_addr_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_wdata_o = 8'h00;
  end
  // one access, strobe held exactly one edge
  task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data);
    @(posedge mclk_i);
    #2;
    reg_addr_o = addr;
    reg_wr_o = wr;
    reg_rd_o = !wr;
    reg_wdata_o = wr ? data : ~data;
    @(posedge mclk_i);
    #2;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    // released data must not keep showing the last byte
    reg_wdata_o = ~reg_wdata_o;
  endtask
endmodule // gxp_master
`default_nettype wire

// File: testbench/testbench.sv
// self-checking bench for the gpio port
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import gxp_pkg::*;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [15:0] ext = 16'h1234;
  wire logic [7:0] addr, wdata, rdata;
  wire logic wr, rd, irq_out, irq_oe;
  wire logic [15:0] pin_out, pin_oe, pull;
  wire logic [15:0] pads = (pin_oe & pin_out) | (~pin_oe & ext);
  int err_total = 0;
  int total_checks = 0;
  // offset, write data, expected readback
  logic [23:0] rows [11] = '{24'h02a5a5, 24'h035a5a, 24'h040f0f, 24'h05f0f0, 24'h083c3c,
    24'h09c3c3, 24'h0c0000, 24'h140000, 24'h150000, 24'h0eff00, 24'h207700};
  // rise, fall, irq after rising edge, irq after falling back
  logic [3:0] modes [4] = '{4'b0010, 4'b1011, 4'b0101, 4'b1111};
  always #12.5 mclk_i = ~mclk_i;
  gxp_master i_gxp_master (.mclk_i(mclk_i), .reg_addr_o(addr), .reg_wr_o(wr),
    .reg_rd_o(rd), .reg_wdata_o(wdata));
  gxp_port i_gxp_port (.mclk_i(mclk_i), .resetn_i(resetn_i), .reg_addr_i(addr),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .gpio_in_i(pads), .gpio_out_o(pin_out), .gpio_oe_o(pin_oe), .pullup_en_o(pull),
    .irq_n_out_o(irq_out), .irq_n_oe_o(irq_oe));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
    i_gxp_master.access(1'b0, a, 8'h00);
    check({8'h00, rdata}, {8'h00, exp});
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    i_gxp_master.access(1'b1, a, d);
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #2;
  endtask
  task automatic results;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // whole run is near four hundred cycles; twenty-five times that is a hang
  initial begin
    #250000;
    err_total++;
    results;
  end
  initial begin
    wait_cyc(20);
    resetn_i = 1'b1;
    foreach (rows[i]) begin
      wr_reg(rows[i][23:16], rows[i][15:8]);
      rd_check(rows[i][23:16], rows[i][7:0]);
    end
    wr_reg(8'h06, 8'hf0);
    wait_cyc(4);
    check(pin_oe, 16'h000f);
    check(pin_out, 16'h5aa5);
    check(pull, 16'hc330);
    rd_check(8'h00, 8'h35);
    wr_reg(8'h00, 8'hff);
    rd_check(8'h00, 8'h35);
    // pin 0 three-stated: pad shows the outside level, state still the latch
    wr_reg(8'h0c, 8'h01);
    check(pin_oe, 16'h000e);
    wait_cyc(4);
    rd_check(8'h00, 8'h35);
    rd_check(8'h01, 8'he2);
    wr_reg(8'h0b, 8'h01);
    foreach (modes[m]) begin
      wr_reg(8'h11, {7'h00, modes[m][3]});
      wr_reg(8'h13, {7'h00, modes[m][2]});
      rd_check(8'h01, 8'he2);
      ext[8] = 1'b1;
      wait_cyc(5);
      check({15'h0, irq_oe}, {15'h0, modes[m][1]});
      ext[8] = 1'b0;
      wait_cyc(5);
      check({15'h0, irq_oe}, {15'h0, modes[m][0]});
      rd_check(8'h0f, {7'h00, modes[m][0]});
      rd_check(8'h01, 8'he2);
      wait_cyc(2);
      check({15'h0, irq_oe}, 16'h0000);
    end
    wr_reg(8'h0b, 8'h00);
    ext[8] = 1'b1;
    wait_cyc(5);
    check({15'h0, irq_oe}, 16'h0000);
    ext[8] = 1'b0;
    wait_cyc(5);
    wr_reg(8'h07, 8'hfe);
    wr_reg(8'h0b, 8'h01);
    wr_reg(8'h03, 8'h5b);
    wait_cyc(5);
    check({15'h0, irq_oe}, 16'h0000);
    // pin 10 with filter on: short pulse rejected, long level accepted
    wr_reg(8'h15, 8'h04);
    wr_reg(8'h0b, 8'h04);
    ext[10] = 1'b1;
    wait_cyc(30);
    ext[10] = 1'b0;
    wait_cyc(60);
    check({15'h0, irq_oe}, 16'h0000);
    ext[10] = 1'b1;
    wait_cyc(35);
    check({15'h0, irq_oe}, 16'h0000);
    wait_cyc(20);
    check({15'h0, irq_oe}, 16'h0001);
    check({15'h0, irq_out}, 16'h0000);
    resetn_i = 1'b0;
    wait_cyc(2);
    check(pin_oe, 16'h0000);
    check(pull, 16'h0000);
    check({15'h0, irq_oe}, 16'h0000);
    resetn_i = 1'b1;
    rd_check(8'h06, 8'hff);
    rd_check(8'h14, 8'hff);
    rd_check(8'h0a, 8'h00);
    rd_check(8'h02, 8'hff);
    results;
  end
endmodule // testbench
`default_nettype wire
